// >>> rtl/acs_pkg.sv
package acs_pkg;
   localparam int LOC_W = 18;
   localparam int LEN_W = 16;
   localparam int PER_W = 16;
   localparam int VOL_W = 7;
   localparam logic [6:0] VOL_MAX = 7'h40;
   localparam logic [7:0] SAMPLE_ZERO = 8'h00;
   // Direct output stalls after this many sample intervals without a fresh word.
   localparam logic [1:0] STARVE_INTERVALS = 2'h2;
   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_FETCH = 2'b01,
      ACS_PLAY = 2'b10
   } acs_state_t;
endpackage

// >>> rtl/acs_channel.sv
`timescale 1ns/1ps
// Operation
// R1: With one buffer programmed the data pointer returns to the buffer start after each pass.
// R2: With DMA enabled the interrupt fires right after the start address is fetched.
// R3: With DMA disabled the interrupt fires each time a written word has been sent out.
// R4: In direct mode a word missing for two sample intervals freezes the output at its last value.
// R5: Volume and period act the same in direct mode as in DMA playback.
// R6: Each sample byte is a signed value from -128 to 127.
// R7: When the length count reaches zero the location and length reload and the wave repeats.
// R8: In DMA mode the interrupt comes once location and length are copied to working registers.
// R9: A period down-counter decremented each tick times every sample interval.
module acs_channel #(
   parameter int LOC_W = acs_pkg::LOC_W,
   parameter int LEN_W = acs_pkg::LEN_W,
   parameter int PER_W = acs_pkg::PER_W
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic dma_en_i,
   input wire logic [LOC_W-1:0] loc_i,
   input wire logic [LEN_W-1:0] len_i,
   input wire logic [PER_W-1:0] period_i,
   input wire logic [acs_pkg::VOL_W-1:0] volume_i,
   input wire logic [15:0] direct_data_i,
   input wire logic direct_wr_i,
   output logic mem_req_o,
   output logic [LOC_W-1:0] mem_addr_o,
   input wire logic mem_ack_i,
   input wire logic [15:0] mem_data_i,
   output logic signed [7:0] dac_sample_o,
   output logic [acs_pkg::VOL_W-1:0] dac_volume_o,
   output logic dac_strobe_o,
   output logic irq_o
);
   acs_pkg::acs_state_t state;
   acs_pkg::acs_state_t next_state;
   logic [LOC_W-1:0] work_loc;
   logic [LEN_W-1:0] work_len;
   logic [PER_W-1:0] per_cnt;
   logic [15:0] word_buf;
   logic word_full;
   logic byte_sel;
   logic [1:0] starve;
   logic [15:0] direct_word;
   logic direct_new;
   logic per_exp;
   logic need_word;
   logic playing;
   logic byte_ready;
   logic play_byte;
   logic mem_take;
   logic direct_take;
   logic word_take;
   logic last_word;
   logic starved;
   logic next_irq;
   logic [acs_pkg::VOL_W-1:0] next_volume;

   function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic lo);
      pick_byte = lo ? w[7:0] : w[15:8];
   endfunction

   function automatic logic [acs_pkg::VOL_W-1:0] clamp_volume(
      input logic [acs_pkg::VOL_W-1:0] v
   );
      clamp_volume = (v > acs_pkg::VOL_MAX) ? acs_pkg::VOL_MAX : v;
   endfunction

   assign playing = (state == acs_pkg::ACS_PLAY);
   assign per_exp = playing && (per_cnt <= PER_W'(1));
   assign byte_ready = word_full || byte_sel;
   assign play_byte = per_exp && byte_ready;
   assign need_word = per_exp && byte_sel;
   assign mem_req_o = dma_en_i && playing && !word_full;
   assign mem_addr_o = work_loc;
   assign mem_take = mem_req_o && mem_ack_i;
   assign direct_take = !dma_en_i && direct_new && !word_full;
   assign word_take = mem_take || direct_take;
   assign last_word = (work_len <= LEN_W'(1));
   assign next_volume = clamp_volume(volume_i);
   // Direct playback gives up only when nothing is buffered and nothing is pending.
   assign starved = !dma_en_i && !direct_new && !word_full
      && (starve >= acs_pkg::STARVE_INTERVALS);

   always_comb begin
      next_state = state;
      case (state)
         acs_pkg::ACS_IDLE: begin
            if (dma_en_i || direct_wr_i) begin
               next_state = acs_pkg::ACS_FETCH;
            end
         end
         acs_pkg::ACS_FETCH: begin
            next_state = acs_pkg::ACS_PLAY;
         end
         acs_pkg::ACS_PLAY: begin
            if (starved) begin
               next_state = acs_pkg::ACS_IDLE; // [R4]
            end else if (mem_take && last_word) begin
               next_state = acs_pkg::ACS_FETCH; // [R1] [R7]
            end
         end
         default: next_state = acs_pkg::ACS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state <= acs_pkg::ACS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Working copies are taken in the fetch state, which is also where a pass wraps.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         work_loc <= '0;
         work_len <= '0;
      end else if (state == acs_pkg::ACS_FETCH) begin
         work_loc <= loc_i; // [R8]
         work_len <= len_i; // [R8]
      end else if (mem_take && !last_word) begin
         work_loc <= work_loc + LOC_W'(1); // [R1]
         work_len <= work_len - LEN_W'(1); // [R7]
      end
   end

   // The down-counter sets the sample rate in both modes.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         per_cnt <= '0;
      end else if (!playing || per_exp) begin
         per_cnt <= period_i; // [R9] [R5]
      end else begin
         per_cnt <= per_cnt - PER_W'(1); // [R9]
      end
   end

   // A direct write wins over clearing the pending flag; the previous pending word is still handed off to word_buf.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         direct_word <= '0;
         direct_new <= 1'b0;
      end else if (direct_wr_i && !dma_en_i) begin
         direct_word <= direct_data_i;
         direct_new <= 1'b1;
      end else if (direct_take) begin
         direct_new <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         word_buf <= '0;
      end else if (mem_take) begin
         word_buf <= mem_data_i;
      end else if (direct_take) begin
         word_buf <= direct_word;
      end
   end

   // Loads only reach an empty buffer, so a load never meets the low-byte clear.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         word_full <= 1'b0;
      end else if (word_take) begin
         word_full <= 1'b1;
      end else if (need_word) begin
         word_full <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         byte_sel <= 1'b0;
      end else if (!playing) begin
         byte_sel <= 1'b0;
      end else if (play_byte) begin
         byte_sel <= ~byte_sel;
      end
   end

   // Counts sample intervals that passed with nothing to play.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         starve <= '0;
      end else if (!playing || play_byte) begin
         starve <= '0;
      end else if (per_exp && (starve < acs_pkg::STARVE_INTERVALS)) begin
         starve <= starve + 2'h1; // [R4]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         dac_sample_o <= $signed(acs_pkg::SAMPLE_ZERO);
         dac_strobe_o <= 1'b0;
      end else begin
         dac_strobe_o <= play_byte;
         if (play_byte) begin
            dac_sample_o <= $signed(pick_byte(word_buf, byte_sel)); // [R6]
         end
      end
   end

   // Interrupt timing depends on the data source.
   always_comb begin
      next_irq = 1'b0;
      if (dma_en_i) begin
         next_irq = (state == acs_pkg::ACS_FETCH); // [R2] [R8]
      end else begin
         next_irq = need_word && word_full; // [R3]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= next_irq;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         dac_volume_o <= '0;
      end else begin
         dac_volume_o <= next_volume; // [R5]
      end
   end
endmodule

// >>> tb/acs_props_properties.sv
`timescale 1ns/1ps
module acs_props (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic dma_en_i,
   input wire logic mem_req_o,
   input wire logic signed [7:0] dac_sample_o,
   input wire logic [acs_pkg::VOL_W-1:0] dac_volume_o,
   input wire logic dac_strobe_o,
   input wire logic irq_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   irq_pulse_a: assert property (irq_o |=> !irq_o) else $error("irq long");
   strobe_pulse_a: assert property (dac_strobe_o |=> !dac_strobe_o) else $error("strobe long");
   sample_hold_a: assert property (!dac_strobe_o |-> $stable(dac_sample_o)) else $error("moved");
   vol_clamp_a: assert property (dac_volume_o <= acs_pkg::VOL_MAX) else $error("vol");
   reset_quiet_a: assert property (disable iff (1'b0)
      reset_i |=> !irq_o && !dac_strobe_o && !mem_req_o) else $error("busy in reset");
   dma_irq_a: assert property (dma_en_i && irq_o |-> !$past(mem_req_o)) else $error("dma irq");
   direct_irq_a: assert property (!dma_en_i && irq_o |->
      dac_strobe_o || $past(dac_strobe_o)) else $error("direct irq");
   direct_src_a: assert property (!dma_en_i && !$past(dma_en_i) |-> !mem_req_o)
      else $error("fetch in direct mode");
endmodule
bind acs_channel acs_props chk_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
   .dma_en_i(dma_en_i), .mem_req_o(mem_req_o), .dac_sample_o(dac_sample_o),
   .dac_volume_o(dac_volume_o), .dac_strobe_o(dac_strobe_o), .irq_o(irq_o));

// >>> tb/acs_mem_model.sv
`timescale 1ns/1ps
module acs_mem_model (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic [17:0] addr_i,
   input wire logic slow_i,
   output logic ack_o = 1'b0,
   output logic [15:0] data_o = 16'h0
);
   logic [1:0] wait_cnt = 2'h0;
   // Outside an ack the data lines toggle so stale words are never mistaken for fresh ones.
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      data_o <= ~data_o;
      wait_cnt <= req_i ? wait_cnt + 2'h1 : 2'h0;
      if (req_i && !ack_o && (!slow_i || wait_cnt == 2'h3)) begin
         ack_o <= 1'b1;
         data_o <= addr_i[15:0] ^ 16'h5a3c;
      end
   end
endmodule

// >>> tb/acs_channel_tb_top.sv
`timescale 1ns/1ps
module acs_channel_tb_top;
   logic sys_clk_i = 1'b0, reset_i = 1'b1, dma_en_i = 1'b0, direct_wr_i = 1'b0, slow = 1'b0;
   logic [17:0] loc_i = 18'h0, mem_addr_o;
   logic [15:0] len_i = 16'h2, period_i = 16'h4, direct_data_i = 16'h0, mem_data_i, w;
   logic [15:0] w0, w1, w2;
   logic [6:0] volume_i = 7'h0, dac_volume_o;
   logic mem_req_o, mem_ack_i, dac_strobe_o, irq_o;
   logic signed [7:0] dac_sample_o;
   logic [31:0] seed = 32'hceafb275;
   int mismatches = 0, checks_done = 0, irqs = 0;
   int cyc = 0, last_strobe = 0, gap = 0;
   logic [7:0] got[$];
   always #20 sys_clk_i = ~sys_clk_i;
   acs_channel dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .dma_en_i(dma_en_i),
      .loc_i(loc_i), .len_i(len_i), .period_i(period_i), .volume_i(volume_i),
      .direct_data_i(direct_data_i), .direct_wr_i(direct_wr_i), .mem_req_o(mem_req_o),
      .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i),
      .dac_sample_o(dac_sample_o), .dac_volume_o(dac_volume_o),
      .dac_strobe_o(dac_strobe_o), .irq_o(irq_o));
   acs_mem_model mem_u (.clk_i(sys_clk_i), .req_i(mem_req_o), .addr_i(mem_addr_o),
      .slow_i(slow), .ack_o(mem_ack_i), .data_o(mem_data_i));
   always @(posedge sys_clk_i) begin
      cyc++;
      if (dac_strobe_o === 1'b1) begin
         got.push_back(dac_sample_o);
         gap = cyc - last_strobe;
         last_strobe = cyc;
      end
      if (irq_o === 1'b1) irqs++;
   end
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] word_at(logic [17:0] a);
      return a[15:0] ^ 16'h5a3c;
   endfunction
   task automatic chk(logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic wait_got(int n);
      for (int i = 0; i < 400 && got.size() < n; i++) tick(1);
      chk(8'(got.size()), 8'(n));
   endtask
   task automatic restart(logic dma);
      reset_i <= 1'b1;
      tick(12);
      seed = lfsr(seed);
      loc_i <= seed[17:0];
      volume_i <= seed[31:25];
      period_i <= {14'h1, seed[19:18]};
      slow <= seed[20];
      w = seed[15:0] ^ 16'h9e21;
      dma_en_i <= dma;
      reset_i <= 1'b0;
      got.delete();
      irqs = 0;
   endtask
   task automatic end_of_test();
      $display("checks_done %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #400000;
      mismatches++;
      end_of_test();
   end
   initial begin
      for (int k = 0; k < 4; k++) begin
         restart(1'b1);
         tick(4);
         w0 = word_at(loc_i);
         w1 = word_at(loc_i + 18'h1);
         chk(8'(irqs), 8'h1);
         chk(8'(got.size()), 8'h0);
         wait_got(5);
         chk(got[0], w0[15:8]);
         chk(got[1], w0[7:0]);
         chk(got[2], w1[15:8]);
         chk(got[3], w1[7:0]);
         chk(got[4], w0[15:8]);
         chk(8'(irqs), 8'h2);
         chk({1'b0, dac_volume_o}, {1'b0, (volume_i > 7'h40) ? 7'h40 : volume_i});
         restart(1'b0);
         if (k == 0) w = 16'h807f;
         seed = lfsr(seed);
         w2 = seed[15:0];
         tick(2);
         direct_data_i <= w;
         direct_wr_i <= 1'b1;
         tick(1);
         direct_wr_i <= 1'b0;
         tick(1);
         direct_data_i <= w2;
         direct_wr_i <= 1'b1;
         tick(1);
         direct_wr_i <= 1'b0;
         wait_got(4);
         tick(4);
         chk(8'(irqs), 8'h2);
         chk(8'(gap), period_i[7:0]);
         tick(20 * int'(period_i));
         chk(8'(got.size()), 8'h4);
         chk(got[0], w[15:8]);
         chk(got[1], w[7:0]);
         chk(got[2], w2[15:8]);
         chk(dac_sample_o, w2[7:0]);
         chk({1'b0, dac_volume_o}, {1'b0, (volume_i > 7'h40) ? 7'h40 : volume_i});
      end
      end_of_test();
   end
endmodule
